// ---- hw/dual_parallel_port_pkg.sv ----
package dual_parallel_port_pkg;

    // Register-select codes, {reg_select_high, reg_select_low}
    localparam logic [1:0] SEL_SIDE_A_DATA = 2'h0;
    localparam logic [1:0] SEL_SIDE_A_CTL = 2'h1;
    localparam logic [1:0] SEL_SIDE_B_DATA = 2'h2;
    localparam logic [1:0] SEL_SIDE_B_CTL = 2'h3;

    // Control register field positions
    localparam int BIT_LINE1_IRQ_EN = 0;
    localparam int BIT_LINE1_RISING = 1;
    localparam int BIT_ACCESS_SELECT = 2;
    localparam int BIT_LINE2_CTL_LO = 3;
    localparam int BIT_LINE2_CTL_HI = 4;
    localparam int BIT_LINE2_DIRECTION = 5;
    localparam int BIT_LINE2_FLAG = 6;
    localparam int BIT_LINE1_FLAG = 7;
    localparam int CTL_WRITABLE_MSB = 5;

    // Side indices
    localparam int SIDE_A = 0;
    localparam int SIDE_B = 1;
    localparam int NUM_SIDES = 2;

    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] DDR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'h00;

endpackage

// ---- hw/dual_parallel_port_adapter.sv ----
module dual_parallel_port_adapter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Processor bus
    input wire logic enable,
    input wire logic readWrite,
    input wire logic chipSelectFirst,
    input wire logic chipSelectSecond,
    input wire logic chipSelectThirdN,
    input wire logic regSelectLow,
    input wire logic regSelectHigh,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut,
    output logic dataOeN,
    // Side A peripheral
    input wire logic [WIDTH-1:0] sideAPortIn,
    output logic [WIDTH-1:0] sideAPortOut,
    output logic [WIDTH-1:0] sideAPortOeN,
    input wire logic sideAEventIn,
    input wire logic sideAControlIn,
    output logic sideAControlOut,
    output logic sideAControlOeN,
    output logic sideAIrqN,
    // Side B peripheral
    input wire logic [WIDTH-1:0] sideBPortIn,
    output logic [WIDTH-1:0] sideBPortOut,
    output logic [WIDTH-1:0] sideBPortOeN,
    input wire logic sideBEventIn,
    input wire logic sideBControlIn,
    output logic sideBControlOut,
    output logic sideBControlOeN,
    output logic sideBIrqN
);

    localparam int NS = dual_parallel_port_pkg::NUM_SIDES;

    typedef struct packed {
        logic enPrev;
        logic selLatch;
        logic [1:0] rsLatch;
        logic rwLatch;
        logic [WIDTH-1:0] dataLatch;
        logic [NS-1:0][7:0] ctl;
        logic [NS-1:0][WIDTH-1:0] ddr;
        logic [NS-1:0][WIDTH-1:0] outReg;
        logic [NS-1:0][WIDTH-1:0] portOeN;
        logic [NS-1:0] ev1Prev;
        logic [NS-1:0] ev2Prev;
        logic [NS-1:0] arm;
        logic [NS-1:0] line2Out;
        logic [NS-1:0] line2OeN;
        logic [NS-1:0] irqN;
        logic [WIDTH-1:0] readData;
        logic readOeN;
    } state_t;

    localparam state_t RESET_STATE = '{
        ctl: {NS{dual_parallel_port_pkg::CTL_RESET}},
        ddr: {NS{dual_parallel_port_pkg::DDR_RESET}},
        outReg: {NS{dual_parallel_port_pkg::OUT_RESET}},
        portOeN: '1,
        line2Out: '1,
        line2OeN: '1,
        irqN: '1,
        readOeN: 1'b1,
        default: '0
    };

    state_t state_ff;
    state_t nxt_state;

    logic fall;
    logic chipSel;
    logic [1:0] rs;
    logic [NS-1:0][WIDTH-1:0] pinIn;
    logic [NS-1:0] eventIn;
    logic [NS-1:0] line2In;
    logic [NS-1:0] act1;
    logic [NS-1:0] act2;
    logic [NS-1:0] rdData;
    logic [NS-1:0] wrData;
    logic [NS-1:0] wrCtl;
    logic [7:0] c;
    logic [7:0] nc;
    logic side;

    always_comb begin
        nxt_state = state_ff;
        fall = state_ff.enPrev & ~enable;
        chipSel = chipSelectFirst & chipSelectSecond & ~chipSelectThirdN;
        rs = {regSelectHigh, regSelectLow};
        pinIn[dual_parallel_port_pkg::SIDE_A] = sideAPortIn;
        pinIn[dual_parallel_port_pkg::SIDE_B] = sideBPortIn;
        eventIn = {sideBEventIn, sideAEventIn};
        line2In = {sideBControlIn, sideAControlIn};
        nxt_state.enPrev = enable;
        // Selects held through the pulse, so the last high cycle is used at the trailing edge
        if (enable) begin
            nxt_state.selLatch = chipSel;
            nxt_state.rsLatch = rs;
            nxt_state.rwLatch = readWrite;
            nxt_state.dataLatch = dataIn;
        end
        for (int i = 0; i < NS; i++) begin
            c = state_ff.ctl[i];
            nc = c;
            act1[i] = c[dual_parallel_port_pkg::BIT_LINE1_RISING] ? (eventIn[i] & ~state_ff.ev1Prev[i])
                                                                  : (~eventIn[i] & state_ff.ev1Prev[i]);
            act2[i] = ~c[dual_parallel_port_pkg::BIT_LINE2_DIRECTION] &
                (c[dual_parallel_port_pkg::BIT_LINE2_CTL_HI] ? (line2In[i] & ~state_ff.ev2Prev[i])
                                                             : (~line2In[i] & state_ff.ev2Prev[i]));
            nxt_state.ev1Prev[i] = eventIn[i];
            nxt_state.ev2Prev[i] = line2In[i];
            rdData[i] = fall & state_ff.selLatch & state_ff.rwLatch & c[dual_parallel_port_pkg::BIT_ACCESS_SELECT]
                & (state_ff.rsLatch == {i[0], 1'b0});
            wrData[i] = fall & state_ff.selLatch & ~state_ff.rwLatch & (state_ff.rsLatch == {i[0], 1'b0});
            wrCtl[i] = fall & state_ff.selLatch & ~state_ff.rwLatch & (state_ff.rsLatch == {i[0], 1'b1});
            // Re-arm only on a deselected enable pulse
            if (enable & ~chipSel) begin
                nxt_state.arm[i] = 1'b1;
            end
            if (rdData[i]) begin
                nxt_state.arm[i] = 1'b0;
            end
            // Set beats a simultaneous clear
            nc[dual_parallel_port_pkg::BIT_LINE1_FLAG] = (act1[i] & state_ff.arm[i])
                | (c[dual_parallel_port_pkg::BIT_LINE1_FLAG] & ~rdData[i]);
            nc[dual_parallel_port_pkg::BIT_LINE2_FLAG] = (act2[i] & state_ff.arm[i])
                | (c[dual_parallel_port_pkg::BIT_LINE2_FLAG] & ~rdData[i]);
            if (wrCtl[i]) begin
                nc[dual_parallel_port_pkg::CTL_WRITABLE_MSB:0] =
                    state_ff.dataLatch[dual_parallel_port_pkg::CTL_WRITABLE_MSB:0];
            end
            if (wrData[i]) begin
                if (c[dual_parallel_port_pkg::BIT_ACCESS_SELECT]) begin
                    nxt_state.outReg[i] = state_ff.dataLatch;
                end else begin
                    nxt_state.ddr[i] = state_ff.dataLatch;
                end
            end
            // Second line output: manual level, or handshake/pulse on a side access
            // New control word, so level and drive enable move on the same edge
            if (nc[dual_parallel_port_pkg::BIT_LINE2_DIRECTION]) begin
                if (nc[dual_parallel_port_pkg::BIT_LINE2_CTL_HI]) begin
                    nxt_state.line2Out[i] = nc[dual_parallel_port_pkg::BIT_LINE2_CTL_LO];
                end else if ((i == dual_parallel_port_pkg::SIDE_A) ? rdData[i] : wrData[i]) begin
                    nxt_state.line2Out[i] = 1'b0;
                end else if (~c[dual_parallel_port_pkg::BIT_LINE2_CTL_LO] & act1[i]) begin
                    nxt_state.line2Out[i] = 1'b1;
                end else if (c[dual_parallel_port_pkg::BIT_LINE2_CTL_LO] & fall) begin
                    nxt_state.line2Out[i] = 1'b1;
                end
            end else begin
                nxt_state.line2Out[i] = 1'b1;
            end
            nxt_state.ctl[i] = nc;
            nxt_state.line2OeN[i] = ~nc[dual_parallel_port_pkg::BIT_LINE2_DIRECTION];
            nxt_state.portOeN[i] = ~nxt_state.ddr[i];
            nxt_state.irqN[i] = ~((nc[dual_parallel_port_pkg::BIT_LINE1_FLAG]
                                  & nc[dual_parallel_port_pkg::BIT_LINE1_IRQ_EN])
                                 | (nc[dual_parallel_port_pkg::BIT_LINE2_FLAG]
                                  & nc[dual_parallel_port_pkg::BIT_LINE2_CTL_LO]));
        end
        // Read path drives the bus only while selected for read inside the pulse
        side = rs[1];
        if (enable & chipSel & readWrite) begin
            nxt_state.readOeN = 1'b0;
            unique case (rs)
                dual_parallel_port_pkg::SEL_SIDE_A_CTL,
                dual_parallel_port_pkg::SEL_SIDE_B_CTL: begin
                    nxt_state.readData = state_ff.ctl[side];
                end
                dual_parallel_port_pkg::SEL_SIDE_A_DATA: begin
                    nxt_state.readData = state_ff.ctl[side][dual_parallel_port_pkg::BIT_ACCESS_SELECT]
                        ? pinIn[side] : state_ff.ddr[side];
                end
                dual_parallel_port_pkg::SEL_SIDE_B_DATA: begin
                    nxt_state.readData = state_ff.ctl[side][dual_parallel_port_pkg::BIT_ACCESS_SELECT]
                        ? ((state_ff.ddr[side] & state_ff.outReg[side]) | (~state_ff.ddr[side] & pinIn[side]))
                        : state_ff.ddr[side];
                end
            endcase
        end else begin
            nxt_state.readOeN = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign dataOut = state_ff.readData;
    assign dataOeN = state_ff.readOeN;
    assign sideAPortOut = state_ff.outReg[dual_parallel_port_pkg::SIDE_A];
    assign sideAPortOeN = state_ff.portOeN[dual_parallel_port_pkg::SIDE_A];
    assign sideAControlOut = state_ff.line2Out[dual_parallel_port_pkg::SIDE_A];
    assign sideAControlOeN = state_ff.line2OeN[dual_parallel_port_pkg::SIDE_A];
    assign sideAIrqN = state_ff.irqN[dual_parallel_port_pkg::SIDE_A];
    assign sideBPortOut = state_ff.outReg[dual_parallel_port_pkg::SIDE_B];
    assign sideBPortOeN = state_ff.portOeN[dual_parallel_port_pkg::SIDE_B];
    assign sideBControlOut = state_ff.line2Out[dual_parallel_port_pkg::SIDE_B];
    assign sideBControlOeN = state_ff.line2OeN[dual_parallel_port_pkg::SIDE_B];
    assign sideBIrqN = state_ff.irqN[dual_parallel_port_pkg::SIDE_B];

endmodule // dual_parallel_port_adapter

// ---- testbench/port_adapter_checker_asserts.sv ----
module port_adapter_checker #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Processor bus
    input wire logic enable,
    input wire logic readWrite,
    input wire logic chipSelectFirst,
    input wire logic chipSelectSecond,
    input wire logic chipSelectThirdN,
    input wire logic dataOeN,
    // Peripheral side
    input wire logic [WIDTH-1:0] sideAPortOeN,
    input wire logic sideAControlOeN,
    input wire logic sideAIrqN,
    input wire logic sideBIrqN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic enD1_ff, enD2_ff, rwD1_ff, rwD2_ff;
    logic wrDone, accDone, rdSel;
    always_ff @(posedge clk) begin
        {enD1_ff, enD2_ff, rwD1_ff, rwD2_ff} <= {enable, enD1_ff, readWrite, rwD1_ff};
    end
    // Trailing edge seen one edge late, as the register update lands
    assign accDone = enD2_ff & ~enD1_ff;
    assign wrDone = accDone & ~rwD2_ff;
    assign rdSel = enable & chipSelectFirst & chipSelectSecond & ~chipSelectThirdN & readWrite;
    a_reset_clean: assert property ($fell(rst) |-> dataOeN && sideAIrqN && sideBIrqN && sideAControlOeN
        && (&sideAPortOeN)) else $error("outputs not cleared by reset");
    a_read_drive: assert property (rdSel |=> !dataOeN) else $error("read not driven");
    a_drive_cause: assert property (!dataOeN |-> $past(rdSel)) else $error("bus driven unasked");
    a_drive_release: assert property ($rose(dataOeN) |-> !$past(enable)) else $error("early release");
    a_dir_write: assert property ($changed(sideAPortOeN) |-> wrDone) else $error("direction moved");
    a_line_mode: assert property ($changed(sideAControlOeN) |-> wrDone) else $error("line mode moved");
    a_irqa_clear: assert property ($rose(sideAIrqN) |-> accDone) else $error("irq A cleared oddly");
    a_irqb_clear: assert property ($rose(sideBIrqN) |-> accDone) else $error("irq B cleared oddly");
    c_read: cover property (rdSel ##1 !dataOeN);
    c_irq_a: cover property ($fell(sideAIrqN));
    c_irq_b: cover property ($fell(sideBIrqN));
endmodule // port_adapter_checker

bind dual_parallel_port_adapter port_adapter_checker #(.WIDTH(WIDTH)) port_adapter_checker_inst (
    .clk, .rst, .enable, .readWrite, .chipSelectFirst, .chipSelectSecond, .chipSelectThirdN,
    .dataOeN, .sideAPortOeN, .sideAControlOeN, .sideAIrqN, .sideBIrqN
);

// ---- testbench/host_bus_model.sv ----
module host_bus_model (
    // Clock
    input wire logic clk,
    // Bus toward the adapter
    output logic enable,
    output logic readWrite,
    output logic chipSelectFirst,
    output logic chipSelectSecond,
    output logic chipSelectThirdN,
    output logic regSelectLow,
    output logic regSelectHigh,
    output logic [7:0] dataIn,
    input wire logic [7:0] dataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {enable, readWrite, chipSelectFirst, chipSelectSecond, chipSelectThirdN} = 5'h09;
        {regSelectHigh, regSelectLow, dataIn} = 10'h000;
    end
    // Selects held through the whole pulse; data line scrambled once let go
    task automatic acc(input logic r, input logic [1:0] s, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        {enable, readWrite, regSelectHigh, regSelectLow, dataIn} = {1'b1, r, s, d};
        {chipSelectFirst, chipSelectSecond, chipSelectThirdN} = 3'h6;
        repeat (2) @(posedge clk);
        #1;
        q = dataOut;
        {enable, chipSelectFirst, chipSelectSecond, chipSelectThirdN, dataIn} = {4'h1, ~d};
    endtask
    // Deselected pulse rearms the flags
    task automatic idle();
        @(posedge clk);
        #1;
        enable = 1'b1;
        @(posedge clk);
        #1;
        enable = 1'b0;
    endtask
endmodule // host_bus_model

// ---- testbench/dual_parallel_port_adapter_tb.sv ----
module dual_parallel_port_adapter_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable, readWrite, chipSelectFirst, chipSelectSecond, chipSelectThirdN, regSelectLow, regSelectHigh;
    logic [7:0] dataIn, dataOut, sideAPortOut, sideBPortOut, sideAPortOeN, sideBPortOeN, q;
    logic [7:0] sideAPortIn = 8'h00;
    logic [7:0] sideBPortIn = 8'h00;
    logic sideAEventIn = 1'b0;
    logic sideAControlIn = 1'b0;
    logic sideBEventIn = 1'b0;
    logic sideBControlIn = 1'b0;
    logic dataOeN, sideAControlOut, sideAControlOeN, sideAIrqN, sideBControlOut, sideBControlOeN, sideBIrqN;
    int n_fail = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    dual_parallel_port_adapter dual_parallel_port_adapter_inst (.clk, .rst, .enable, .readWrite,
        .chipSelectFirst, .chipSelectSecond, .chipSelectThirdN, .regSelectLow, .regSelectHigh, .dataIn,
        .dataOut, .dataOeN, .sideAPortIn, .sideAPortOut, .sideAPortOeN, .sideAEventIn, .sideAControlIn,
        .sideAControlOut, .sideAControlOeN, .sideAIrqN, .sideBPortIn, .sideBPortOut, .sideBPortOeN,
        .sideBEventIn, .sideBControlIn, .sideBControlOut, .sideBControlOeN, .sideBIrqN);
    host_bus_model host_bus_model_inst (.clk, .enable, .readWrite, .chipSelectFirst, .chipSelectSecond,
        .chipSelectThirdN, .regSelectLow, .regSelectHigh, .dataIn, .dataOut);
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        host_bus_model_inst.acc(1'b0, s, d, q);
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] exp);
        host_bus_model_inst.acc(1'b1, s, 8'h00, q);
        cmp(q, exp);
    endtask
    task automatic t_reset();
        cmp(sideAPortOeN & sideBPortOeN, 8'hFF);
        cmp({sideAControlOeN, sideBControlOeN, sideAIrqN, sideBIrqN, dataOeN, 3'h7}, 8'hFF);
        rd(2'h1, 8'h00);
        rd(2'h0, 8'h00);
    endtask
    task automatic t_ctl();
        wr(2'h1, 8'hFF);
        rd(2'h1, 8'h3F);
        wr(2'h1, 8'h30);
        repeat (2) tick();
        cmp({6'h00, sideAControlOeN, sideAControlOut}, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h3F);
        wr(2'h1, 8'h00);
        repeat (2) tick();
        cmp({6'h00, sideAControlOeN, sideBControlOeN}, 8'h02);
    endtask
    task automatic t_port();
        wr(2'h0, 8'hF0);
        repeat (2) tick();
        cmp(sideAPortOeN, 8'h0F);
        rd(2'h0, 8'hF0);
        wr(2'h1, 8'h04);
        wr(2'h0, 8'hA5);
        repeat (2) tick();
        cmp(sideAPortOut, 8'hA5);
        sideAPortIn = 8'h3C;
        rd(2'h0, 8'h3C);
        wr(2'h3, 8'h00);
        wr(2'h2, 8'hF0);
        wr(2'h3, 8'h04);
        wr(2'h2, 8'hA5);
        repeat (2) tick();
        cmp(sideBPortOut, 8'hA5);
        cmp(sideBPortOeN, 8'h0F);
        sideBPortIn = 8'h3C;
        rd(2'h2, 8'hAC);
    endtask
    task automatic t_irq();
        wr(2'h1, 8'h07);
        host_bus_model_inst.idle();
        sideAEventIn = 1'b1;
        repeat (3) tick();
        cmp({7'h00, sideAIrqN}, 8'h00);
        rd(2'h1, 8'h87);
        rd(2'h0, 8'h3C);
        repeat (2) tick();
        cmp({7'h00, sideAIrqN}, 8'h01);
        sideAEventIn = 1'b0;
        tick();
        sideAEventIn = 1'b1;
        repeat (3) tick();
        rd(2'h1, 8'h07);
        host_bus_model_inst.idle();
        sideAEventIn = 1'b0;
        tick();
        sideAEventIn = 1'b1;
        repeat (3) tick();
        rd(2'h1, 8'h87);
        wr(2'h1, 8'h26);
        rd(2'h0, 8'h3C);
        tick();
        cmp({7'h00, sideAControlOut}, 8'h00);
        sideAEventIn = 1'b0;
        tick();
        sideAEventIn = 1'b1;
        repeat (2) tick();
        cmp({7'h00, sideAControlOut}, 8'h01);
    endtask
    task automatic t_line2();
        wr(2'h3, 8'h1C);
        host_bus_model_inst.idle();
        sideBControlIn = 1'b1;
        repeat (3) tick();
        cmp({7'h00, sideBIrqN}, 8'h00);
        rd(2'h3, 8'h5C);
        rd(2'h2, 8'hAC);
        wr(2'h3, 8'h34);
        sideBControlIn = 1'b0;
        repeat (2) tick();
        cmp({6'h00, sideBControlOeN, sideBControlOut}, 8'h00);
        host_bus_model_inst.idle();
        sideBControlIn = 1'b1;
        repeat (3) tick();
        rd(2'h3, 8'h34);
    endtask
    task automatic end_sim();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_ctl();
        t_port();
        t_irq();
        t_line2();
        end_sim();
    end
    // Tests need about 150 cycles; ample margin before giving up
    initial begin
        #50000;
        n_fail++;
        end_sim();
    end
endmodule // dual_parallel_port_adapter_tb
